// ---- async_list_regs.sv ----
// Aperiodic transfer list registers, buffer data port and descriptor walker.
// Assumes host strobes and engine pulses are synchronous to clk.
// Notes on behaviour
// - Buffer size resets to 512 bytes; buffer memory holds up to 4096 bytes.
// - Every data port access sequence starts at buffer address zero.
// - Code 44h reads the buffer, C4h writes it, then data words stream.
// - The buffer pointer advances automatically after each port access.
// - Pointer reaching transfer count raises all-ended flag and status update.
// - Block size lives in bits 9:0, resets to zero, upper bits reserved.
// - Done bit n sets when descriptor n completes with an acknowledge.
// - Done bits update at once as each descriptor finishes.
// - Reading the done bitmap clears it; reset value zero.
// - Descriptors with skip bit set are passed over until software clears it.
// - After the descriptor marked last, processing wraps to descriptor zero.
// - Active index is read-only in bits 4:0, resets to zero.
// - Buffer size codes 34/B4, block size codes 54/D4.
// - Skip bitmap codes 1C/9C; done bitmap read-only at 1B.
// - Last bitmap codes 1D/9D; active index read-only at 1E.
module async_list_regs #(
  parameter int unsigned BUF_BYTES = async_list_pkg::BUF_MAX_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire async_list_pkg::cpu_req_t cpu_req,
  output logic cpu_rd_ready,
  output logic [15:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic [15:0] transfer_count,
  output logic all_transfers_ended,
  output logic buffer_status_update,
  input wire logic desc_done,
  input wire logic desc_advance,
  output logic [4:0] active_index,
  output logic desc_valid,
  output logic [15:0] desc_offset,
  input wire logic [$clog2(BUF_BYTES/2)-1:0] eng_rd_addr,
  output logic [15:0] eng_rd_data,
  output logic [15:0] buffer_size,
  output logic [9:0] block_size
);

  localparam int unsigned AW = $clog2(BUF_BYTES / 2);

  // Decoding used only by the command phase logic
  function automatic logic is_wide(input logic [7:0] code);
    is_wide = (code[6:0] == async_list_pkg::CMD_DONE_RD[6:0])
      || (code[6:0] == async_list_pkg::CMD_SKIP_RD[6:0])
      || (code[6:0] == async_list_pkg::CMD_LAST_RD[6:0]);
  endfunction

  function automatic async_list_pkg::access_t kind_of(input logic [7:0] code);
    if (code == async_list_pkg::CMD_PORT_RD)
    begin
      kind_of = async_list_pkg::ACC_PORT_RD;
    end
    else if (code == async_list_pkg::CMD_PORT_WR)
    begin
      kind_of = async_list_pkg::ACC_PORT_WR;
    end
    else if (code == async_list_pkg::CMD_RESET)
    begin
      kind_of = async_list_pkg::ACC_IDLE;
    end
    else
    begin
      kind_of = async_list_pkg::ACC_REG;
    end
  endfunction

  logic [7:0] cmd;
  logic phase;
  logic [15:0] wr_hold;
  logic [15:0] done_hi_hold;
  logic [31:0] done_map;
  logic [31:0] skip_map;
  logic [31:0] last_map;
  logic [15:0] ptr;
  logic [15:0] fetch_ptr;
  logic inflight;
  logic [15:0] mem_rd_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [15:0] rd_word;
  async_list_pkg::access_t mode;

  // Host side decode
  wire cmd_take = cpu_req.wr && cpu_req.cmd;
  wire data_wr = cpu_req.wr && !cpu_req.cmd;
  wire data_rd = cpu_req.rd && !cpu_req.cmd && cpu_rd_ready;
  wire data_acc = data_wr || data_rd;
  wire [7:0] new_cmd = cpu_req.wdata[7:0];
  wire port_rd_pop = data_rd && mode == async_list_pkg::ACC_PORT_RD;
  wire port_wr = data_wr && mode == async_list_pkg::ACC_PORT_WR;
  wire port_step = port_rd_pop || port_wr;
  wire wide_commit = data_wr && phase;
  wire [31:0] wide_word = {cpu_req.wdata, wr_hold};
  wire done_clear = data_rd && cmd == async_list_pkg::CMD_DONE_RD && !phase;
  wire [31:0] done_set = desc_done ? (32'h0000_0001 << active_index) : 32'h0000_0000;
  wire [31:0] next_done = (done_clear ? async_list_pkg::MAP_RESET : done_map) | done_set;
  wire fetch_issue = mode == async_list_pkg::ACC_PORT_RD && !inflight && fifo_in_ready
    && fetch_ptr < transfer_count;
  wire [15:0] next_ptr = ptr + async_list_pkg::PTR_STEP;
  wire hit_count = port_step && ptr < transfer_count && next_ptr >= transfer_count;
  wire skip_now = skip_map[active_index];
  wire step_desc = desc_advance || skip_now;
  wire [4:0] next_index = last_map[active_index] ? async_list_pkg::INDEX_RESET
    : active_index + 5'h01;

  // Port reads stall the host until a prefetched word is waiting
  assign cpu_rd_ready = (mode == async_list_pkg::ACC_PORT_RD) ? fifo_out_valid : 1'b1;
  assign desc_valid = !skip_now;

  // Read data selection; 32-bit maps give the low half first
  always_comb
  begin
    case (cmd)
      async_list_pkg::CMD_DONE_RD: rd_word = phase ? done_hi_hold : done_map[15:0];
      async_list_pkg::CMD_SKIP_RD: rd_word = phase ? skip_map[31:16] : skip_map[15:0];
      async_list_pkg::CMD_LAST_RD: rd_word = phase ? last_map[31:16] : last_map[15:0];
      async_list_pkg::CMD_ACTIVE_RD: rd_word = {11'h000, active_index};
      async_list_pkg::CMD_BUFSIZE_RD: rd_word = buffer_size;
      async_list_pkg::CMD_BLK_RD: rd_word = {6'h00, block_size};
      async_list_pkg::CMD_PORT_RD: rd_word = fifo_out_data;
      default: rd_word = 16'h0000;
    endcase
  end

  // Command phase and word pairing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd <= async_list_pkg::CMD_RESET;
      mode <= async_list_pkg::ACC_IDLE;
      phase <= 1'b0;
      wr_hold <= 16'h0000;
    end
    else if (cmd_take)
    begin
      cmd <= new_cmd;
      mode <= kind_of(new_cmd);
      phase <= 1'b0;
    end
    else if (data_acc && is_wide(cmd))
    begin
      phase <= !phase;
      wr_hold <= cpu_req.wdata;
    end
  end

  // Writable registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      buffer_size <= async_list_pkg::BUFSIZE_RESET;
      block_size <= async_list_pkg::BLK_RESET;
      skip_map <= async_list_pkg::MAP_RESET;
      last_map <= async_list_pkg::MAP_RESET;
    end
    else
    begin
      if (data_wr && cmd == async_list_pkg::CMD_BUFSIZE_WR)
      begin
        buffer_size <= cpu_req.wdata;
      end
      if (data_wr && cmd == async_list_pkg::CMD_BLK_WR)
      begin
        block_size <= cpu_req.wdata[9:0];
      end
      if (wide_commit && cmd == async_list_pkg::CMD_SKIP_WR)
      begin
        skip_map <= wide_word;
      end
      if (wide_commit && cmd == async_list_pkg::CMD_LAST_WR)
      begin
        last_map <= wide_word;
      end
    end
  end

  // Done bitmap: a completion in the clearing cycle survives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_map <= async_list_pkg::MAP_RESET;
      done_hi_hold <= 16'h0000;
    end
    else
    begin
      done_map <= next_done;
      if (done_clear)
      begin
        done_hi_hold <= done_map[31:16];
      end
    end
  end

  // Read answer, one cycle after the strobe is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_rdata <= 16'h0000;
      cpu_rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= data_rd;
      if (data_rd)
      begin
        cpu_rdata <= rd_word;
      end
    end
  end

  // Buffer pointers; each new port command restarts them at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr <= async_list_pkg::PTR_START;
      fetch_ptr <= async_list_pkg::PTR_START;
      inflight <= 1'b0;
    end
    else if (cmd_take)
    begin
      ptr <= async_list_pkg::PTR_START;
      fetch_ptr <= async_list_pkg::PTR_START;
      inflight <= 1'b0;
    end
    else
    begin
      inflight <= fetch_issue;
      if (fetch_issue)
      begin
        fetch_ptr <= fetch_ptr + async_list_pkg::PTR_STEP;
      end
      if (port_step)
      begin
        ptr <= next_ptr;
      end
    end
  end

  // End of transfer pulses; the count comes from the transfer counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      all_transfers_ended <= 1'b0;
      buffer_status_update <= 1'b0;
    end
    else
    begin
      all_transfers_ended <= hit_count;
      buffer_status_update <= hit_count;
    end
  end

  // Descriptor walker; all-skipped lists simply keep circling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_index <= async_list_pkg::INDEX_RESET;
      desc_offset <= 16'h0000;
    end
    else
    begin
      if (step_desc)
      begin
        active_index <= next_index;
      end
      desc_offset <= 16'({11'h000, active_index} * {6'h00, block_size});
    end
  end

  // Memory sized for the largest buffer; addresses wrap beyond it
  buffer_memory #(
    .WORDS(BUF_BYTES / 2),
    .AW(AW),
    .W(16)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(port_wr),
    .wr_addr(ptr[AW:1]),
    .wr_data(cpu_req.wdata),
    .rd_a_addr(fetch_ptr[AW:1]),
    .rd_a_data(mem_rd_data),
    .rd_b_addr(eng_rd_addr),
    .rd_b_data(eng_rd_data)
  );

  // Prefetch buffer: a slow reader stalls fetching, no word is lost
  two_entry_buffer #(
    .W(16)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(cmd_take),
    .in_valid(inflight),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(port_rd_pop),
    .out_data(fifo_out_data)
  );

endmodule // async_list_regs

// ---- async_list_pkg.sv ----
// Shared constants and types for the aperiodic transfer list register set.
// Assumes every user compiles this package first and refers to it by scope.
package async_list_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned MAP_W = 32;
  localparam int unsigned BLK_W = 10;
  localparam int unsigned IDX_W = 5;

  // Command codes, read codes have bit 7 clear, write codes have it set
  localparam logic [7:0] CMD_DONE_RD = 8'h1B;
  localparam logic [7:0] CMD_SKIP_RD = 8'h1C;
  localparam logic [7:0] CMD_SKIP_WR = 8'h9C;
  localparam logic [7:0] CMD_LAST_RD = 8'h1D;
  localparam logic [7:0] CMD_LAST_WR = 8'h9D;
  localparam logic [7:0] CMD_ACTIVE_RD = 8'h1E;
  localparam logic [7:0] CMD_BUFSIZE_RD = 8'h34;
  localparam logic [7:0] CMD_BUFSIZE_WR = 8'hB4;
  localparam logic [7:0] CMD_PORT_RD = 8'h44;
  localparam logic [7:0] CMD_PORT_WR = 8'hC4;
  localparam logic [7:0] CMD_BLK_RD = 8'h54;
  localparam logic [7:0] CMD_BLK_WR = 8'hD4;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Values after reset
  localparam logic [15:0] BUFSIZE_RESET = 16'h0200;
  localparam logic [BLK_W-1:0] BLK_RESET = 10'h000;
  localparam logic [MAP_W-1:0] MAP_RESET = 32'h0000_0000;
  localparam logic [IDX_W-1:0] INDEX_RESET = 5'h00;
  localparam logic [15:0] PTR_START = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0002;

  // Largest buffer the device holds, in bytes
  localparam int unsigned BUF_MAX_BYTES = 4096;

  // One access from the host processor; cmd high is the command phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic cmd;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef enum {ACC_IDLE, ACC_REG, ACC_PORT_RD, ACC_PORT_WR} access_t;

endpackage

// ---- buffer_memory.sv ----
// Word memory behind the aperiodic buffer: one write port, two read ports.
// Assumes one clock; read data appear one cycle after the address.
module buffer_memory #(
  parameter int unsigned WORDS = 2048,
  parameter int unsigned AW = 11,
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [W-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [W-1:0] rd_b_data
);

  logic [W-1:0] mem [WORDS];

  // The array itself has no reset, only the read registers do
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule // buffer_memory

// ---- two_entry_buffer.sv ----
// Two-word buffer with valid and ready on both sides and a flush.
// Assumes producer and consumer share the clock.
module two_entry_buffer #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] slot [2];
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire wr_idx = (count == 2'd2 && pop) || (count == 2'd1 && !pop);

  assign in_ready = count != 2'd2;
  assign out_valid = count != 2'd0;
  assign out_data = slot[0];

  always_ff @(posedge clk)
  begin
    if (pop)
    begin
      slot[0] <= slot[1];
    end
    if (push)
    begin
      slot[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= 2'd0;
    end
    else if (flush)
    begin
      count <= 2'd0;
    end
    else
    begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // two_entry_buffer

// ---- async_list_regs_checker.sv ----
// Concurrent checks on the ports of the aperiodic transfer list registers.
// Assumes one clock and the asynchronous, active high reset of the design.
module async_list_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire async_list_pkg::cpu_req_t cpu_req,
  input wire logic cpu_rd_ready,
  input wire logic cpu_rvalid,
  input wire logic all_transfers_ended,
  input wire logic buffer_status_update,
  input wire logic desc_advance,
  input wire logic desc_valid,
  input wire logic [4:0] active_index,
  input wire logic [15:0] desc_offset,
  input wire logic [15:0] buffer_size,
  input wire logic [9:0] block_size
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  logic taken;
  assign taken = cpu_req.rd & ~cpu_req.cmd & cpu_rd_ready;

  a_read_answer: assert property (taken |=> cpu_rvalid)
    else $error("taken read got no answer");
  a_answer_cause: assert property (cpu_rvalid |-> $past(taken))
    else $error("answer without a taken read");
  a_end_status: assert property (all_transfers_ended == buffer_status_update)
    else $error("end flag and status update apart");
  a_index_step: assert property ($changed(active_index) |->
    active_index == 5'h00 || active_index == $past(active_index) + 5'h01)
    else $error("active index jumped");
  a_index_hold: assert property (desc_valid && !desc_advance |=> $stable(active_index))
    else $error("index moved without cause");
  a_skip_steps: assert property (!desc_valid && active_index != 5'h00 |=>
    active_index != $past(active_index))
    else $error("skipped descriptor not passed over");
  // Widen before multiplying so the product keeps all sixteen bits
  a_offset_product: assert property (desc_offset ==
    {6'h00, $past(block_size)} * {11'h000, $past(active_index)})
    else $error("descriptor offset wrong");
  a_bufsize_written: assert property ($changed(buffer_size) |->
    $past(cpu_req.wr) && !$past(cpu_req.cmd))
    else $error("buffer size changed without a write");
  a_blksize_written: assert property ($changed(block_size) |->
    $past(cpu_req.wr) && !$past(cpu_req.cmd))
    else $error("block size changed without a write");

  cover property (all_transfers_ended);
  cover property (!desc_valid ##1 desc_valid);
  cover property (desc_advance ##1 active_index == 5'h00);
endmodule // async_list_regs_checker

bind async_list_regs async_list_regs_checker i_async_list_regs_checker (
  .clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_rd_ready(cpu_rd_ready),
  .cpu_rvalid(cpu_rvalid), .all_transfers_ended(all_transfers_ended),
  .buffer_status_update(buffer_status_update), .desc_advance(desc_advance),
  .desc_valid(desc_valid), .active_index(active_index), .desc_offset(desc_offset),
  .buffer_size(buffer_size), .block_size(block_size)
);

// ---- host_cpu_model.sv ----
// Host processor model: command and data phases on the host port.
// Assumes tasks are called from one process and clk runs freely.
module host_cpu_model (
  input wire logic clk,
  input wire logic cpu_rd_ready,
  input wire logic cpu_rvalid,
  input wire logic [15:0] cpu_rdata,
  output async_list_pkg::cpu_req_t cpu_req,
  output logic [15:0] transfer_count
);
  initial
  begin
    cpu_req = '0;
    transfer_count = 16'h0000;
  end

  task automatic load_count(input logic [15:0] n);
    @(posedge clk);
    transfer_count <= n;
  endtask

  // Strobes drop after each phase so one access is never taken twice
  task automatic put(input logic c, input logic [15:0] d);
    @(posedge clk);
    cpu_req <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
    @(posedge clk);
    cpu_req <= '0;
  endtask

  task automatic cmd(input logic [7:0] code);
    put(1'b1, {8'h00, code});
  endtask

  task automatic wr(input logic [15:0] d);
    put(1'b0, d);
  endtask

  // Read is held until ready is seen high; ok low means it never completed
  task automatic rd(output logic [15:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    cpu_req <= '{wr: 1'b0, rd: 1'b1, cmd: 1'b0, wdata: 16'h0000};
    @(posedge clk);
    while (cpu_rd_ready !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge clk);
    end
    // The answer stands only in the cycle after the taking edge, so look just after it
    cpu_req <= '0;
    #1;
    ok = cpu_rvalid;
    d = cpu_rdata;
  endtask
endmodule // host_cpu_model

// ---- async_list_regs_bench.sv ----
// Self-checking bench for the aperiodic transfer list registers.
// Assumes the host model drives the host port; engine pulses come from here.
module async_list_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, cpu_rd_ready, cpu_rvalid, all_transfers_ended, buffer_status_update;
  logic desc_done, desc_advance, desc_valid, ok;
  async_list_pkg::cpu_req_t cpu_req;
  logic [15:0] cpu_rdata, transfer_count, desc_offset, eng_rd_data, buffer_size, rdv;
  logic [4:0] active_index;
  logic [10:0] eng_rd_addr;
  logic [9:0] block_size;
  int n_errors = 0;
  int checked = 0;
  int n_end = 0;

  async_list_regs i_async_list_regs (
    .clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_rd_ready(cpu_rd_ready),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .transfer_count(transfer_count),
    .all_transfers_ended(all_transfers_ended), .buffer_status_update(buffer_status_update),
    .desc_done(desc_done), .desc_advance(desc_advance), .active_index(active_index),
    .desc_valid(desc_valid), .desc_offset(desc_offset), .eng_rd_addr(eng_rd_addr),
    .eng_rd_data(eng_rd_data), .buffer_size(buffer_size), .block_size(block_size)
  );
  host_cpu_model i_host_cpu_model (
    .clk(clk), .cpu_rd_ready(cpu_rd_ready), .cpu_rvalid(cpu_rvalid),
    .cpu_rdata(cpu_rdata), .cpu_req(cpu_req), .transfer_count(transfer_count)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (all_transfers_ended === 1'b1)
      n_end <= n_end + 1;

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic get(input logic [15:0] want);
    i_host_cpu_model.rd(rdv, ok);
    check({15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1)
      conclude();
    check(rdv, want);
  endtask

  task automatic reg_rd(input logic [7:0] code, input logic [15:0] want);
    i_host_cpu_model.cmd(code);
    get(want);
  endtask

  task automatic reg_wr(input logic [7:0] code, input logic [15:0] d);
    i_host_cpu_model.cmd(code);
    i_host_cpu_model.wr(d);
  endtask

  // Low word first, high word second
  task automatic map_rd(input logic [7:0] code, input logic [31:0] want);
    i_host_cpu_model.cmd(code);
    get(want[15:0]);
    get(want[31:16]);
  endtask

  task automatic map_wr(input logic [7:0] code, input logic [31:0] d);
    reg_wr(code, d[15:0]);
    i_host_cpu_model.wr(d[31:16]);
  endtask

  task automatic pulse(input logic d, input logic a);
    @(posedge clk);
    desc_done <= d;
    desc_advance <= a;
    @(posedge clk);
    desc_done <= 1'b0;
    desc_advance <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic eng_check(input int i, input logic [15:0] want);
    @(posedge clk);
    eng_rd_addr <= 11'(i);
    repeat (2) @(posedge clk);
    #1;
    check(eng_rd_data, want);
  endtask

  initial
  begin
    rst = 1'b1;
    desc_done = 1'b0;
    desc_advance = 1'b0;
    eng_rd_addr = 11'h000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reg_rd(8'h34, 16'h0200);
    reg_rd(8'h54, 16'h0000);
    reg_rd(8'h1E, 16'h0000);
    map_rd(8'h1B, 32'h0000_0000);
    map_rd(8'h1C, 32'h0000_0000);
    map_rd(8'h1D, 32'h0000_0000);
    reg_wr(8'hB4, 16'h1000);
    reg_rd(8'h34, 16'h1000);
    check(buffer_size, 16'h1000);
    reg_wr(8'hD4, 16'hFFF8);
    reg_rd(8'h54, 16'h03F8);
    reg_wr(8'hD4, 16'h0040);
    reg_wr(8'h1E, 16'h001F);
    reg_rd(8'h1E, 16'h0000);
    check({6'h00, block_size}, 16'h0040);
    // Blocks 3 to 6 are among those skipped; the walk ends at block 4
    map_wr(8'h9C, 32'h1234_5678);
    map_rd(8'h1C, 32'h1234_5678);
    map_wr(8'h9D, 32'h0000_0010);
    map_rd(8'h1D, 32'h0000_0010);
    i_host_cpu_model.load_count(16'h0008);
    i_host_cpu_model.cmd(8'hC4);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        check(16'(n_end), 16'h0000);
      i_host_cpu_model.wr(16'hA5A0 + 16'(i));
    end
    repeat (2) @(posedge clk);
    check(16'(n_end), 16'h0001);
    for (int i = 0; i < 4; i++)
      eng_check(i, 16'hA5A0 + 16'(i));
    reg_wr(8'hC4, 16'h5A5A);
    i_host_cpu_model.cmd(8'h00);
    eng_check(0, 16'h5A5A);
    // Host stalls so the read buffer fills before any word is taken
    i_host_cpu_model.cmd(8'h44);
    repeat (8) @(posedge clk);
    get(16'h5A5A);
    for (int i = 1; i < 4; i++)
      get(16'hA5A0 + 16'(i));
    repeat (2) @(posedge clk);
    check(16'(n_end), 16'h0002);
    i_host_cpu_model.cmd(8'h00);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    check({11'h000, active_index}, 16'h0002);
    check(desc_offset, 16'h0080);
    check({15'h0000, desc_valid}, 16'h0001);
    reg_rd(8'h1E, 16'h0002);
    pulse(1'b1, 1'b0);
    map_rd(8'h1B, 32'h0000_0005);
    map_rd(8'h1B, 32'h0000_0000);
    pulse(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    check({11'h000, active_index}, 16'h0000);
    conclude();
  end
endmodule // async_list_regs_bench
